// ### lgr_pkg.sv
// Purpose: shared constants for the unique id, rom map and failed write register bank
// Assumes: avalon-mm slave with 32-bit data, byte addressing
// Notes: offsets are byte addresses
package lgr_pkg;
  localparam int unsigned ADDR_W = 8;
  localparam logic [ADDR_W-1:0] OFS_UID_UPPER = 8'h24;
  localparam logic [ADDR_W-1:0] OFS_UID_LOWER = 8'h28;
  localparam logic [ADDR_W-1:0] OFS_ROM_MAP = 8'h34;
  localparam logic [ADDR_W-1:0] OFS_FAIL_LOW = 8'h38;
  localparam logic [ADDR_W-1:0] OFS_FAIL_HIGH = 8'h3C;
  localparam logic [ADDR_W-1:0] OFS_IRQ_STATUS = 8'h60;
  localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 8'h64;
  localparam logic [ADDR_W-1:0] OFS_UID_STATUS = 8'h68;
  localparam logic [31:0] UID_RESET = 32'h00000000;
  localparam logic [31:0] ROM_MAP_RESET = 32'h00000000;
  localparam logic [31:0] UNMAPPED_DATA = 32'h00000000;
  localparam int unsigned ROM_BASE_LSB = 10;
  localparam int unsigned ROM_OFS_W = 10;
  localparam logic [47:0] ROM_WIN_LO = 48'hFFFFF0000400;
  localparam logic [47:0] ROM_WIN_HI = 48'hFFFFF00007FF;
  localparam int unsigned BUS_NUM_W = 10;
  localparam int unsigned NODE_NUM_W = 6;
  localparam int unsigned IRQ_W = 3;
  localparam int unsigned IRQ_FAIL = 0;
  localparam int unsigned IRQ_UID_LOCK = 1;
  localparam int unsigned IRQ_ROM_HIT = 2;
endpackage : lgr_pkg

// ### lgr_sync2.sv
// Purpose: two flip-flop synchroniser for a level from outside the clock domain
// Assumes: input is a slow level
// Notes: first stage feeds only the second
`timescale 1ns/10ps
module lgr_sync2 (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic asyncIn,
  output logic syncOut
);
  logic stage1_r;
  // two-stage capture
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      stage1_r <= 1'b0;
      syncOut <= 1'b0;
    end else begin
      stage1_r <= asyncIn;
      syncOut <= stage1_r;
    end
  end
endmodule : lgr_sync2

// ### lgr_rom_map.sv
// Purpose: maps configuration rom quadlet reads into host memory addresses
// Assumes: request fields are stable while romReqValid is high
// Notes: one cycle of latency, combinational window compare
`timescale 1ns/10ps
module lgr_rom_map
  import lgr_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [31:0] romBase,
  input wire logic romReqValid,
  input wire logic [47:0] romReqOffset,
  output logic romHostValid,
  output logic [31:0] romHostAddr
);
  logic inWindow;
  // request falls inside the rom window
  assign inWindow = (romReqOffset >= ROM_WIN_LO) && (romReqOffset <= ROM_WIN_HI);
  // base plus low offset bits gives host address
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      romHostValid <= 1'b0;
      romHostAddr <= 32'h00000000;
    end else begin
      romHostValid <= romReqValid && inWindow;
      if (romReqValid && inWindow) begin
        romHostAddr <= romBase + 32'(romReqOffset[ROM_OFS_W-1:0]);
      end
    end
  end
endmodule : lgr_rom_map

// ### lgr_regs.sv
// Purpose: register bank for the node unique id, rom mapping and failed posted write capture
// Assumes: avalon-mm master honours waitrequest; eeprom loader and link logic share sys_clk
// Notes: eeprom detect arrives from a pin and is synchronised
`timescale 1ns/10ps
// Summary of operation
// - hardware reset clears both id quadlets
// - eeprom load then lock id registers
// - upper id quadlet at 24h, written once by firmware when no eeprom
// - lower quadlet at 28h behaves identically
// - rom read host address is base plus offset bits 9:0
// - rom base bits 31:10 rw, low zero
// - failed posted write recorded in error registers
// - low error register holds offset low 32
// - high error register 15:0 holds offset upper
// - high error bits 31:16 hold bus, node
module lgr_regs
  import lgr_pkg::*;
#(
  parameter int unsigned ADDR_BITS = ADDR_W
)
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // power reset from its pin
  input wire logic power_on_reset_pin,
  // avalon-mm slave
  input wire logic [ADDR_BITS-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // serial eeprom loader
  input wire logic eepromPresentPin,
  input wire logic eepromLoadValid,
  input wire logic [63:0] eepromUniqueId,
  // configuration rom reads from the link
  input wire logic romReqValid,
  input wire logic [47:0] romReqOffset,
  output logic romHostValid,
  output logic [31:0] romHostAddr,
  // failed posted write reports
  input wire logic failValid,
  input wire logic [47:0] failDestOffset,
  input wire logic [BUS_NUM_W-1:0] failBusNum,
  input wire logic [NODE_NUM_W-1:0] failNodeNum,
  // interrupt and loaded id
  output logic irq,
  output logic [63:0] node_unique_identifier
);
  // bus handshake state
  typedef enum logic [1:0] {BUS_IDLE, BUS_ACK} lgr_bus_e;
  lgr_bus_e busState_r;
  logic busWrite;
  logic busRead;

  // synchronised pins and power reset tracking
  logic eepromPresent;
  logic porSync;
  logic porSeen_r;

  // id quadlets and their load control
  logic uidLocked_r;
  logic uidUpperDone_r;
  logic uidLowerDone_r;
  logic [31:0] uidUpper_r;
  logic [31:0] uidLower_r;
  logic eepromLoad;
  logic fwLoadOk;
  logic fwWriteUpper;
  logic fwWriteLower;
  logic lockEvent;
  logic [3:0] uidStatus;

  // rom mapping
  logic [31:0] romBase_r;
  logic [31:0] romBaseMerged;
  logic romHostValidInt;
  logic [31:0] romHostAddrInt;

  // failed posted write capture
  logic [31:0] failLow_r;
  logic [31:0] failHigh_r;

  // interrupts
  logic [IRQ_W-1:0] irqStatus_r;
  logic [IRQ_W-1:0] irqMask_r;
  logic [IRQ_W-1:0] irqEvent;
  logic [IRQ_W-1:0] irqPending;

  // read path
  logic [31:0] readMux;

  // byte-lane merge for partial writes
  function automatic logic [31:0] lgr_merge(input logic [31:0] oldVal, input logic [31:0] newVal,
                                            input logic [3:0] be);
    logic [31:0] res;
    res = oldVal;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        res[i*8 +: 8] = newVal[i*8 +: 8];
      end
    end
    return res;
  endfunction : lgr_merge

  // synchronise pin-level inputs
  lgr_sync2 u_sync_eeprom (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .asyncIn(eepromPresentPin),
    .syncOut(eepromPresent)
  );
  lgr_sync2 u_sync_por (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .asyncIn(power_on_reset_pin),
    .syncOut(porSync)
  );

  // rom read address mapping
  lgr_rom_map u_rom_map (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .romBase(romBase_r),
    .romReqValid(romReqValid),
    .romReqOffset(romReqOffset),
    .romHostValid(romHostValidInt),
    .romHostAddr(romHostAddrInt)
  );

  // bus request is taken in the ack cycle
  assign busWrite = (busState_r == BUS_ACK) && avs_write;
  assign busRead = (busState_r == BUS_ACK) && avs_read;

  // handshake state: one ack cycle per request
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      busState_r <= BUS_IDLE;
    end else begin
      unique case (busState_r)
        BUS_IDLE: begin
          if (avs_read || avs_write) begin
            busState_r <= BUS_ACK;
          end
        end
        BUS_ACK: begin
          busState_r <= BUS_IDLE;
        end
      endcase
    end
  end

  // waitrequest low only in the ack cycle, so every access has one wait state
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      avs_waitrequest <= 1'b1;
    end else begin
      avs_waitrequest <= !(busState_r == BUS_IDLE && (avs_read || avs_write));
    end
  end

  // power reset seen: loading is allowed only after it
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      porSeen_r <= 1'b0;
    end else if (porSync) begin
      porSeen_r <= 1'b1;
    end
  end

  // load paths: eeprom when present, firmware otherwise, both only after power reset
  assign eepromLoad = porSeen_r && eepromPresent && !uidLocked_r && eepromLoadValid;
  assign fwLoadOk = porSeen_r && !eepromPresent && !uidLocked_r;
  assign fwWriteUpper = fwLoadOk && busWrite && avs_address == OFS_UID_UPPER && !uidUpperDone_r;
  assign fwWriteLower = fwLoadOk && busWrite && avs_address == OFS_UID_LOWER && !uidLowerDone_r;

  // upper id quadlet: cleared on reset, loaded once
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      uidUpper_r <= UID_RESET;
    end else if (eepromLoad) begin
      uidUpper_r <= eepromUniqueId[63:32];
    end else if (fwWriteUpper) begin
      uidUpper_r <= lgr_merge(uidUpper_r, avs_writedata, avs_byteenable);
    end
  end

  // lower id quadlet: same reset and load as the upper one
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      uidLower_r <= UID_RESET;
    end else if (eepromLoad) begin
      uidLower_r <= eepromUniqueId[31:0];
    end else if (fwWriteLower) begin
      uidLower_r <= lgr_merge(uidLower_r, avs_writedata, avs_byteenable);
    end
  end

  // upper quadlet written: later writes are ignored
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      uidUpperDone_r <= 1'b0;
    end else if (eepromLoad || fwWriteUpper) begin
      uidUpperDone_r <= 1'b1;
    end
  end

  // lower quadlet written: later writes are ignored
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      uidLowerDone_r <= 1'b0;
    end else if (eepromLoad || fwWriteLower) begin
      uidLowerDone_r <= 1'b1;
    end
  end

  // lock once both quadlets are loaded
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      uidLocked_r <= 1'b0;
    end else if (uidUpperDone_r && uidLowerDone_r) begin
      uidLocked_r <= 1'b1;
    end
  end

  assign lockEvent = uidUpperDone_r && uidLowerDone_r && !uidLocked_r;

  // byte lanes merged before the low bits are dropped
  assign romBaseMerged = lgr_merge(romBase_r, avs_writedata, avs_byteenable);

  // rom base register, low bits forced to zero
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      romBase_r <= ROM_MAP_RESET;
    end else if (busWrite && avs_address == OFS_ROM_MAP) begin
      romBase_r <= {romBaseMerged[31:ROM_BASE_LSB], {ROM_BASE_LSB{1'b0}}};
    end
  end

  // failed write, low offset word: no reset value, hardware update only
  always_ff @(posedge sys_clk) begin
    if (failValid) begin
      failLow_r <= failDestOffset[31:0];
    end
  end

  // failed write, requester and upper offset bits: no reset value
  always_ff @(posedge sys_clk) begin
    if (failValid) begin
      failHigh_r <= {failBusNum, failNodeNum, failDestOffset[47:32]};
    end
  end

  // interrupt events
  assign irqEvent[IRQ_FAIL] = failValid;
  assign irqEvent[IRQ_UID_LOCK] = lockEvent;
  assign irqEvent[IRQ_ROM_HIT] = romHostValidInt;

  // sticky status, read clears, a new event wins
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      irqStatus_r <= '0;
    end else if (busRead && avs_address == OFS_IRQ_STATUS) begin
      irqStatus_r <= irqEvent;
    end else begin
      irqStatus_r <= irqStatus_r | irqEvent;
    end
  end

  // interrupt mask
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      irqMask_r <= '0;
    end else if (busWrite && avs_address == OFS_IRQ_MASK && avs_byteenable[0]) begin
      irqMask_r <= avs_writedata[IRQ_W-1:0];
    end
  end

  // unmasked status, counting an event of this cycle
  assign irqPending = (irqStatus_r | irqEvent) & irqMask_r;

  // interrupt output from current status
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |irqPending;
    end
  end

  // id status word: presence, power reset seen, lower written, locked
  assign uidStatus = {eepromPresent, porSeen_r, uidLowerDone_r, uidLocked_r};

  // read decode
  always_comb begin
    readMux = UNMAPPED_DATA;
    unique case (avs_address)
      OFS_UID_UPPER: readMux = uidUpper_r;
      OFS_UID_LOWER: readMux = uidLower_r;
      OFS_ROM_MAP: readMux = romBase_r;
      OFS_FAIL_LOW: readMux = failLow_r;
      OFS_FAIL_HIGH: readMux = failHigh_r;
      OFS_IRQ_STATUS: readMux = 32'(irqStatus_r);
      OFS_IRQ_MASK: readMux = 32'(irqMask_r);
      OFS_UID_STATUS: readMux = 32'(uidStatus);
      default: readMux = UNMAPPED_DATA;
    endcase
  end

  // read data registered with the ack
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      avs_readdata <= UNMAPPED_DATA;
    end else if (busState_r == BUS_IDLE && avs_read) begin
      avs_readdata <= readMux;
    end
  end

  // registered copy of the rom map answer
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      romHostValid <= 1'b0;
      romHostAddr <= 32'h00000000;
    end else begin
      romHostValid <= romHostValidInt;
      romHostAddr <= romHostAddrInt;
    end
  end

  // registered copy of the full id, upper quadlet first
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      node_unique_identifier <= {UID_RESET, UID_RESET};
    end else begin
      node_unique_identifier <= {uidUpper_r, uidLower_r};
    end
  end
endmodule : lgr_regs

// ### lgr_regs_props.sv
// Purpose: port checks for the id, rom map and failed write bank
// Assumes: one clock, async active-low reset
// Notes: register contents are seen through read data and node_unique_identifier
`timescale 1ns/10ps
module lgr_regs_props
  import lgr_pkg::*;
#(
  parameter int unsigned ADDR_BITS = ADDR_W
)
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [ADDR_BITS-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic romReqValid,
  input wire logic [47:0] romReqOffset,
  input wire logic romHostValid,
  input wire logic [31:0] romHostAddr,
  input wire logic [63:0] node_unique_identifier
);
  logic inWin;
  logic [9:0] ofsLow;
  logic [31:0] uidHi;
  logic [31:0] uidLo;
  // window decode and quadlet split
  assign inWin = romReqValid && romReqOffset >= ROM_WIN_LO && romReqOffset <= ROM_WIN_HI;
  assign ofsLow = romReqOffset[9:0];
  assign uidHi = node_unique_identifier[63:32];
  assign uidLo = node_unique_identifier[31:0];
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);
  AST_WAIT_ANS: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("request not answered in one cycle");
  AST_WAIT_ONE: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  AST_UID_RST: assert property ($rose(rst_n) |-> uidHi == UID_RESET && uidLo == UID_RESET)
    else $error("id not clear after reset");
  AST_UID_HI_ONCE: assert property ($changed(uidHi) |-> $past(uidHi) == UID_RESET)
    else $error("upper id changed twice");
  AST_UID_LO_ONCE: assert property ($changed(uidLo) |-> $past(uidLo) == UID_RESET)
    else $error("lower id changed twice");
  AST_UID_READ: assert property (!avs_waitrequest && $past(avs_read) && $past(avs_address) == OFS_UID_UPPER |->
    avs_readdata == uidHi) else $error("upper id read wrong");
  AST_ROM_LOW: assert property (!avs_waitrequest && $past(avs_read) && $past(avs_address) == OFS_ROM_MAP |->
    avs_readdata[9:0] == 10'h000) else $error("rom base low bits not zero");
  AST_ROM_HIT: assert property (inWin |-> ##2 romHostValid)
    else $error("rom window read not mapped");
  AST_ROM_SRC: assert property (romHostValid |-> $past(inWin, 2) && romHostAddr[9:0] == $past(ofsLow, 2))
    else $error("rom host address wrong");
  // main scenarios
  cover property (inWin);
  cover property ($changed(uidLo));
  cover property (!avs_waitrequest && $past(avs_write));
endmodule : lgr_regs_props
bind lgr_regs lgr_regs_props #(.ADDR_BITS(ADDR_BITS)) props_u (.*);

// ### lgr_link_model.sv
// Purpose: link side of the bank: eeprom loader, power reset pin, rom reads, failed writes
// Assumes: driven by task calls from the bench
// Notes: data lines show inverted values once released
`timescale 1ns/10ps
module lgr_link_model
  import lgr_pkg::*;
(
  input wire logic sys_clk,
  output logic power_on_reset_pin,
  output logic eepromPresentPin,
  output logic eepromLoadValid,
  output logic [63:0] eepromUniqueId,
  output logic romReqValid,
  output logic [47:0] romReqOffset,
  input wire logic romHostValid,
  input wire logic [31:0] romHostAddr,
  output logic failValid,
  output logic [47:0] failDestOffset,
  output logic [BUS_NUM_W-1:0] failBusNum,
  output logic [NODE_NUM_W-1:0] failNodeNum
);
  // quiet link at time zero
  initial begin
    {power_on_reset_pin, eepromPresentPin, eepromLoadValid, romReqValid, failValid} = 5'h00;
    {eepromUniqueId, romReqOffset, failDestOffset, failBusNum, failNodeNum} = '0;
  end
  // power reset pulse, long enough for the synchroniser
  task automatic por(input logic p);
    @(posedge sys_clk);
    power_on_reset_pin <= 1'h1;
    eepromPresentPin <= p;
    repeat (4) @(posedge sys_clk);
    power_on_reset_pin <= 1'h0;
    repeat (3) @(posedge sys_clk);
  endtask : por
  // one-cycle id load from the eeprom
  task automatic load(input logic [63:0] id);
    @(posedge sys_clk);
    eepromLoadValid <= 1'h1;
    eepromUniqueId <= id;
    @(posedge sys_clk);
    eepromLoadValid <= 1'h0;
    eepromUniqueId <= ~id;
  endtask : load
  // quadlet read from a remote node, watch four cycles for the answer
  task automatic rom(input logic [47:0] ofs, output logic hit, output logic [31:0] addr);
    hit = 1'h0;
    addr = 32'h0;
    @(posedge sys_clk);
    romReqValid <= 1'h1;
    romReqOffset <= ofs;
    @(posedge sys_clk);
    romReqValid <= 1'h0;
    romReqOffset <= ~ofs;
    repeat (4) begin
      @(posedge sys_clk);
      if (romHostValid === 1'h1) begin
        hit = 1'h1;
        addr = romHostAddr;
      end
    end
  endtask : rom
  // failed posted write report, then two cycles for the interrupt
  task automatic fail(input logic [47:0] ofs, input logic [9:0] bus, input logic [5:0] node);
    @(posedge sys_clk);
    failValid <= 1'h1;
    {failDestOffset, failBusNum, failNodeNum} <= {ofs, bus, node};
    @(posedge sys_clk);
    failValid <= 1'h0;
    {failDestOffset, failBusNum, failNodeNum} <= ~{ofs, bus, node};
    repeat (2) @(posedge sys_clk);
  endtask : fail
endmodule : lgr_link_model

// ### link_node_unique_identifier_rommap_postwrite_regs_tb_top.sv
// Purpose: register-level tests of the id, rom map and failed write bank
// Assumes: one wait state per avalon access
// Notes: covers firmware and eeprom id paths across two resets
`timescale 1ns/10ps
module link_node_unique_identifier_rommap_postwrite_regs_tb_top;
  import lgr_pkg::*;
  logic sys_clk, rst_n, avs_read, avs_write, avs_waitrequest, irq, eepromPresentPin, eepromLoadValid;
  logic romReqValid, romHostValid, failValid, power_on_reset_pin;
  logic [7:0] avs_address;
  logic [3:0] avs_byteenable;
  logic [31:0] avs_writedata, avs_readdata, romHostAddr;
  logic [63:0] node_unique_identifier, eepromUniqueId;
  logic [47:0] romReqOffset, failDestOffset;
  logic [9:0] failBusNum;
  logic [5:0] failNodeNum;
  int failCount = 0;
  int compares = 0;
  int cycles = 0;
  lgr_regs dut_u (.*);
  lgr_link_model mdl_u (.*);
  // clock and hang guard
  always #20 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      failCount++;
      wrapUp();
    end
  end
  task automatic wt();
    do @(posedge sys_clk); while (avs_waitrequest !== 1'h0);
  endtask : wt
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge sys_clk);
    {avs_address, avs_writedata, avs_write} <= {a, v, 1'h1};
    wt();
    avs_write <= 1'h0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge sys_clk);
    {avs_address, avs_read} <= {a, 1'h1};
    wt();
    v = avs_readdata;
    avs_read <= 1'h0;
  endtask : rd
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    compares++;
    if (got !== exp) begin
      failCount++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic chkRd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] v;
    rd(a, v);
    chk({32'h0, v}, {32'h0, exp});
  endtask : chkRd
  task automatic romChk(input logic [47:0] ofs, input logic eh, input logic [31:0] ea);
    logic h;
    logic [31:0] a;
    mdl_u.rom(ofs, h, a);
    chk({31'h0, h, a}, {31'h0, eh, ea});
  endtask : romChk
  task automatic wrapUp();
    $display("compares %0d mismatches %0d", compares, failCount);
    if (failCount == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : wrapUp
  // main sequence
  initial begin
    {sys_clk, rst_n, avs_read, avs_write, avs_address, avs_writedata} = '0;
    avs_byteenable = 4'hF;
    repeat (4) @(posedge sys_clk);
    rst_n <= 1'h1;
    chkRd(OFS_UID_UPPER, UID_RESET);
    chkRd(OFS_UID_LOWER, UID_RESET);
    chkRd(OFS_ROM_MAP, ROM_MAP_RESET);
    wr(8'hF0, 32'hFFFFFFFF);
    chkRd(8'hF0, UNMAPPED_DATA);
    $display("test reset done");
    mdl_u.por(1'h0);
    wr(OFS_UID_UPPER, 32'h0A0B0C0D);
    wr(OFS_UID_LOWER, 32'h11223344);
    wr(OFS_UID_UPPER, 32'h55555555);
    wr(OFS_UID_LOWER, 32'h66666666);
    chkRd(OFS_UID_UPPER, 32'h0A0B0C0D);
    chkRd(OFS_UID_LOWER, 32'h11223344);
    chk(node_unique_identifier, 64'h0A0B0C0D11223344);
    chkRd(OFS_UID_STATUS, 32'h00000007);
    $display("test firmware id done");
    wr(OFS_ROM_MAP, 32'h123457FF);
    chkRd(OFS_ROM_MAP, 32'h12345400);
    romChk(ROM_WIN_LO, 1'h1, 32'h12345400);
    romChk(ROM_WIN_HI, 1'h1, 32'h123457FF);
    romChk(ROM_WIN_LO - 48'h1, 1'h0, 32'h0);
    romChk(ROM_WIN_HI + 48'h1, 1'h0, 32'h0);
    $display("test rom map done");
    chkRd(OFS_IRQ_STATUS, 32'h00000006);
    wr(OFS_IRQ_MASK, 32'h00000001);
    mdl_u.fail(48'hABCD12345678, 10'h2A5, 6'h1B);
    chk({63'h0, irq}, 64'h1);
    chkRd(OFS_FAIL_LOW, 32'h12345678);
    chkRd(OFS_FAIL_HIGH, {10'h2A5, 6'h1B, 16'hABCD});
    wr(OFS_FAIL_LOW, 32'h0);
    chkRd(OFS_FAIL_LOW, 32'h12345678);
    chkRd(OFS_IRQ_STATUS, 32'h00000001);
    repeat (2) @(posedge sys_clk);
    chk({63'h0, irq}, 64'h0);
    wr(OFS_IRQ_MASK, 32'h0);
    mdl_u.fail(48'h00015555AAAA, 10'h001, 6'h3F);
    chk({63'h0, irq}, 64'h0);
    chkRd(OFS_FAIL_HIGH, {10'h001, 6'h3F, 16'h0001});
    $display("test failed write done");
    @(posedge sys_clk);
    rst_n <= 1'h0;
    repeat (4) @(posedge sys_clk);
    rst_n <= 1'h1;
    chkRd(OFS_UID_UPPER, UID_RESET);
    mdl_u.por(1'h1);
    mdl_u.load(64'hFEDCBA9876543210);
    wr(OFS_UID_LOWER, 32'h0);
    mdl_u.load(64'h1);
    chkRd(OFS_UID_UPPER, 32'hFEDCBA98);
    chkRd(OFS_UID_LOWER, 32'h76543210);
    chkRd(OFS_UID_STATUS, 32'h0000000F);
    $display("test eeprom id done");
    wrapUp();
  end
endmodule : link_node_unique_identifier_rommap_postwrite_regs_tb_top
